// ==== verilog/cma_datapath.sv ====
/*
  Complex multiply-accumulate datapath with auxiliary accumulator and growth detect.
  Assumes sine, cosine and phase word come from logic on clk_i; all controls are pins
  driven synchronously to clk_i.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cma_defs.svh"

module cma_datapath (
  input  wire logic                      clk_i,
  input  wire logic                      sys_rst_i,
  input  wire logic [`CMA_IN_W-1:0]      real_data_in_i,
  input  wire logic [`CMA_IN_W-1:0]      imag_data_in_i,
  input  wire logic                      input_latch_enable_n_i,
  input  wire logic [`CMA_SHIFT_W-1:0]   input_shift_select_i,
  input  wire logic [`CMA_TRIG_W-1:0]    sine_i,
  input  wire logic [`CMA_TRIG_W-1:0]    cosine_i,
  input  wire logic [`CMA_PHASE_W-1:0]   phase_word_i,
  input  wire logic                      phase_bypass_n_i,
  input  wire logic                      accumulate_i,
  input  wire logic [`CMA_SEL_W-1:0]     output_slice_select_i,
  input  wire logic                      unsigned_format_n_i,
  input  wire logic                      peak_hold_n_i,
  output logic      [`CMA_OUT_W-1:0]     real_data_out_o,
  output logic      [`CMA_OUT_W-1:0]     imag_data_out_o,
  output logic      [`CMA_GROW_W-1:0]    growth_code_o
);

  // ----------------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------------
  function automatic cma_pkg::cma_slice_t shift_slice(input cma_pkg::cma_in_t  din,
                                                      input cma_pkg::cma_shift_t sel);
    unique case (sel)
      cma_pkg::CMA_SH_0: shift_slice = din[15:0];
      cma_pkg::CMA_SH_1: shift_slice = din[16:1];
      cma_pkg::CMA_SH_2: shift_slice = din[17:2];
      cma_pkg::CMA_SH_3: shift_slice = din[18:3];
    endcase
  endfunction : shift_slice

  function automatic logic [`CMA_TRIG_W-1:0] clamp_trig(input logic [`CMA_TRIG_W-1:0] v);
    clamp_trig = (v == `CMA_TRIG_ILLEGAL) ? `CMA_TRIG_NEG_FULL : v;
  endfunction : clamp_trig

  function automatic cma_pkg::cma_out_t out_slice(input cma_pkg::cma_acc_t   acc,
                                                  input cma_pkg::cma_out_t   aux,
                                                  input cma_pkg::cma_out_sel_t sel);
    unique case (sel)
      cma_pkg::CMA_OUT_PROD_HI: out_slice = {acc[34:31], acc[30:15]};
      cma_pkg::CMA_OUT_PROD_LO: out_slice = {acc[34:31], 1'b0, acc[14:0]};
      cma_pkg::CMA_OUT_AUX:     out_slice = aux;
      cma_pkg::CMA_OUT_RSVD:    out_slice = `CMA_OUT_RST;
    endcase
  endfunction : out_slice

  function automatic logic [`CMA_GROW_W-1:0] growth_of(input cma_pkg::cma_out_t v);
    if (v[19] != v[18]) begin
      growth_of = 2'h3;
    end else if (v[18] != v[17]) begin
      growth_of = 2'h2;
    end else if (v[17] != v[16]) begin
      growth_of = 2'h1;
    end else begin
      growth_of = 2'h0;
    end
  endfunction : growth_of

  // ----------------------------------------------------------------------
  // Input registers and shifters
  // ----------------------------------------------------------------------
  cma_pkg::cma_in_t    real_in_ff;
  cma_pkg::cma_in_t    imag_in_ff;
  cma_pkg::cma_slice_t real_shift;
  cma_pkg::cma_slice_t imag_shift;
  cma_pkg::cma_shift_t shift_sel;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      real_in_ff <= `CMA_IN_RST;
      imag_in_ff <= `CMA_IN_RST;
    end else if (!input_latch_enable_n_i) begin
      real_in_ff <= real_data_in_i;
      imag_in_ff <= imag_data_in_i;
    end
  end

  assign shift_sel  = cma_pkg::cma_shift_t'(input_shift_select_i);
  assign real_shift = shift_slice(real_in_ff, shift_sel);
  assign imag_shift = shift_slice(imag_in_ff, shift_sel);

  // ----------------------------------------------------------------------
  // Complex multiplier
  // ----------------------------------------------------------------------
  logic signed [`CMA_TRIG_W-1:0] cos_op;
  logic signed [`CMA_TRIG_W-1:0] sin_op;
  logic signed [`CMA_MUL_W-1:0]  rc_prod;
  logic signed [`CMA_MUL_W-1:0]  is_prod;
  logic signed [`CMA_MUL_W-1:0]  rs_prod;
  logic signed [`CMA_MUL_W-1:0]  ic_prod;
  cma_pkg::cma_prod_t            nxt_mult_re;
  cma_pkg::cma_prod_t            nxt_mult_im;
  cma_pkg::cma_prod_t            mult_re_ff;
  cma_pkg::cma_prod_t            mult_im_ff;

  assign cos_op  = phase_bypass_n_i ? clamp_trig(cosine_i) : phase_word_i[15:0];
  assign sin_op  = phase_bypass_n_i ? clamp_trig(sine_i) : phase_word_i[31:16];
  assign rc_prod = real_shift * cos_op;
  assign is_prod = imag_shift * sin_op;
  assign rs_prod = real_shift * sin_op;
  assign ic_prod = imag_shift * cos_op;
  assign nxt_mult_re = {rc_prod[31], rc_prod} - {is_prod[31], is_prod};
  assign nxt_mult_im = {rs_prod[31], rs_prod} + {ic_prod[31], ic_prod};

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mult_re_ff <= `CMA_PROD_RST;
      mult_im_ff <= `CMA_PROD_RST;
    end else begin
      mult_re_ff <= nxt_mult_re;
      mult_im_ff <= nxt_mult_im;
    end
  end

  // ----------------------------------------------------------------------
  // Product accumulators
  // ----------------------------------------------------------------------
  cma_pkg::cma_acc_t mult_re_ext;
  cma_pkg::cma_acc_t mult_im_ext;
  cma_pkg::cma_acc_t acc_re_ff;
  cma_pkg::cma_acc_t acc_im_ff;

  assign mult_re_ext = {{2{mult_re_ff[32]}}, mult_re_ff};
  assign mult_im_ext = {{2{mult_im_ff[32]}}, mult_im_ff};

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      acc_re_ff <= `CMA_ACC_RST;
      acc_im_ff <= `CMA_ACC_RST;
    end else begin
      acc_re_ff <= (accumulate_i ? acc_re_ff : `CMA_ACC_RST) + mult_re_ext;
      acc_im_ff <= (accumulate_i ? acc_im_ff : `CMA_ACC_RST) + mult_im_ext;
    end
  end

  // ----------------------------------------------------------------------
  // Auxiliary complex accumulator
  // ----------------------------------------------------------------------
  logic signed [`CMA_OUT_W-1:0] aux_re;
  logic signed [`CMA_OUT_W-1:0] aux_im;

  cma_aux_accum u_aux_re (
    .clk_i        (clk_i),
    .sys_rst_i    (sys_rst_i),
    .accumulate_i (accumulate_i),
    .sample_i     (real_shift),
    .sum_o        (aux_re)
  );

  cma_aux_accum u_aux_im (
    .clk_i        (clk_i),
    .sys_rst_i    (sys_rst_i),
    .accumulate_i (accumulate_i),
    .sample_i     (imag_shift),
    .sum_o        (aux_im)
  );

  // ----------------------------------------------------------------------
  // Output multiplexer, format and growth detect
  // ----------------------------------------------------------------------
  cma_pkg::cma_out_sel_t     out_sel;
  cma_pkg::cma_out_t         mux_re;
  cma_pkg::cma_out_t         mux_im;
  cma_pkg::cma_out_t         fmt_mask;
  logic [`CMA_GROW_W-1:0]    grow_re;
  logic [`CMA_GROW_W-1:0]    grow_im;
  logic [`CMA_GROW_W-1:0]    grow_now;
  logic [`CMA_GROW_W-1:0]    nxt_growth;

  assign out_sel  = cma_pkg::cma_out_sel_t'(output_slice_select_i);
  assign mux_re   = out_slice(acc_re_ff, aux_re, out_sel);
  assign mux_im   = out_slice(acc_im_ff, aux_im, out_sel);
  assign fmt_mask = {!unsigned_format_n_i, 19'h0_0000};
  assign grow_re  = growth_of(mux_re);
  assign grow_im  = growth_of(mux_im);
  assign grow_now = (grow_re > grow_im) ? grow_re : grow_im;
  assign nxt_growth = (!peak_hold_n_i && growth_code_o > grow_now) ? growth_code_o : grow_now;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      real_data_out_o <= `CMA_OUT_RST;
      imag_data_out_o <= `CMA_OUT_RST;
    end else begin
      real_data_out_o <= mux_re ^ fmt_mask;
      imag_data_out_o <= mux_im ^ fmt_mask;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      growth_code_o <= `CMA_GROW_RST;
    end else begin
      growth_code_o <= nxt_growth;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  a_input_hold: assert property (
    input_latch_enable_n_i |=> real_in_ff == $past(real_in_ff) && imag_in_ff == $past(imag_in_ff))
    else $error("input register changed while latch disabled");

  a_input_load: assert property (
    !input_latch_enable_n_i |=> real_in_ff == $past(real_data_in_i))
    else $error("input register did not load");

  a_shift_top: assert property (
    input_shift_select_i == 2'h3 |-> real_shift == real_in_ff[18:3])
    else $error("shift code 3 picked wrong bits");

  a_trig_range: assert property (
    phase_bypass_n_i |-> sin_op != `CMA_TRIG_ILLEGAL && cos_op != `CMA_TRIG_ILLEGAL)
    else $error("trig operand outside symmetric range");

  a_mult_real_path: assert property (
    1'b1 |=> mult_re_ff == $past(real_shift) * $past(cos_op) - $past(imag_shift) * $past(sin_op))
    else $error("real product wrong");

  a_acc_restart: assert property (
    !accumulate_i |=> acc_re_ff == $past(mult_re_ext) && acc_im_ff == $past(mult_im_ext))
    else $error("accumulator did not restart");

  a_acc_add: assert property (
    accumulate_i |=> acc_re_ff == $past(acc_re_ff) + $past(mult_re_ext))
    else $error("accumulator did not add");

  a_rsvd_zero: assert property (
    output_slice_select_i == 2'h3 |=> real_data_out_o[18:0] == 19'h0_0000)
    else $error("reserved select not zero");

  a_format_msb: assert property (
    !unsigned_format_n_i |=> real_data_out_o[19] != $past(mux_re[19]))
    else $error("unsigned format did not invert msb");

  a_growth_peak: assert property (
    !peak_hold_n_i |=> growth_code_o >= $past(growth_code_o))
    else $error("peak hold lost growth");

endmodule : cma_datapath

`default_nettype wire

// ==== pkg/cma_defs.svh ====
/*
  Widths, codes and fixed values of the complex multiply-accumulate datapath.
  Assumes it is included by its bare name, once per compilation unit or more.
*/
`ifndef CMA_DEFS_SVH
`define CMA_DEFS_SVH

// ----------------------------------------------------------------------
// Widths
// ----------------------------------------------------------------------
`define CMA_IN_W     19
`define CMA_SLICE_W  16
`define CMA_TRIG_W   16
`define CMA_PHASE_W  32
`define CMA_MUL_W    32
`define CMA_PROD_W   33
`define CMA_ACC_W    35
`define CMA_OUT_W    20
`define CMA_GROW_W   2
`define CMA_SHIFT_W  2
`define CMA_SEL_W    2

// ----------------------------------------------------------------------
// Fixed values
// ----------------------------------------------------------------------
`define CMA_TRIG_NEG_FULL  16'h8001
`define CMA_TRIG_ILLEGAL   16'h8000
`define CMA_IN_RST         19'h0_0000
`define CMA_PROD_RST       33'h0_0000_0000
`define CMA_ACC_RST        35'h0_0000_0000
`define CMA_OUT_RST        20'h0_0000
`define CMA_AUX_RST        20'h0_0000
`define CMA_GROW_RST       2'h0
`define CMA_GROW_MAX       2'h3

`endif

// ==== pkg/cma_pkg.sv ====
/*
  Types of the complex multiply-accumulate datapath.
  Assumes cma_defs.svh is on the include path.
*/
`include "cma_defs.svh"

package cma_pkg;

  // ----------------------------------------------------------------------
  // Data types
  // ----------------------------------------------------------------------
  typedef logic        [`CMA_IN_W-1:0]    cma_in_t;
  typedef logic signed [`CMA_SLICE_W-1:0] cma_slice_t;
  typedef logic signed [`CMA_PROD_W-1:0]  cma_prod_t;
  typedef logic signed [`CMA_ACC_W-1:0]   cma_acc_t;
  typedef logic        [`CMA_OUT_W-1:0]   cma_out_t;

  // ----------------------------------------------------------------------
  // Select codes
  // ----------------------------------------------------------------------
  typedef enum logic [`CMA_SHIFT_W-1:0] {
    CMA_SH_0,
    CMA_SH_1,
    CMA_SH_2,
    CMA_SH_3
  } cma_shift_t;

  typedef enum logic [`CMA_SEL_W-1:0] {
    CMA_OUT_PROD_HI,
    CMA_OUT_PROD_LO,
    CMA_OUT_AUX,
    CMA_OUT_RSVD
  } cma_out_sel_t;

endpackage : cma_pkg

// ==== verilog/cma_aux_accum.sv ====
/*
  One lane of the auxiliary complex accumulator.
  Assumes a shifted 16-bit sample and the accumulate control on clk_i.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cma_defs.svh"

module cma_aux_accum (
  input  wire logic                           clk_i,
  input  wire logic                           sys_rst_i,
  input  wire logic                           accumulate_i,
  input  wire logic signed [`CMA_SLICE_W-1:0] sample_i,
  output logic signed      [`CMA_OUT_W-1:0]   sum_o
);

  // ----------------------------------------------------------------------
  // Accumulator
  // ----------------------------------------------------------------------
  logic signed [`CMA_OUT_W-1:0] sample_ext;
  logic signed [`CMA_OUT_W-1:0] nxt_sum;
  logic signed [`CMA_OUT_W-1:0] sum_ff;

  assign sum_o      = sum_ff;
  assign sample_ext = {{(`CMA_OUT_W-`CMA_SLICE_W){sample_i[`CMA_SLICE_W-1]}}, sample_i};
  assign nxt_sum    = (accumulate_i ? sum_ff : `CMA_AUX_RST) + sample_ext;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sum_ff <= `CMA_AUX_RST;
    end else begin
      sum_ff <= nxt_sum;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  a_aux_restart_load: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !accumulate_i |=> sum_ff == $past(sample_ext))
    else $error("aux accumulator did not restart");

  a_aux_accum_add: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    accumulate_i ##1 accumulate_i |=> sum_ff == $past(sum_ff) + $past(sample_ext))
    else $error("aux accumulator did not add");

endmodule : cma_aux_accum

`default_nettype wire

// ==== testbench/cma_trig_src.sv ====
/*
  Far-side model: registered sine/cosine source that feeds the datapath.
  Assumes the bench picks the operand values; they appear one edge later.
*/
`timescale 1ns/1ps
`default_nettype none

module cma_trig_src (
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic [15:0] sin_req_i,
  input  wire logic [15:0] cos_req_i,
  output logic      [15:0] sine_o,
  output logic      [15:0] cosine_o
);
  // ----------------------------------------------------------------------
  // Operand registers
  // ----------------------------------------------------------------------
  logic [15:0] sine_ff;
  logic [15:0] cosine_ff;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sine_ff   <= 16'h0000;
      cosine_ff <= 16'h0000;
    end else begin
      sine_ff   <= sin_req_i;
      cosine_ff <= cos_req_i;
    end
  end

  assign sine_o   = sine_ff;
  assign cosine_o = cosine_ff;
endmodule : cma_trig_src
`default_nettype wire

// ==== testbench/testbench.sv ====
/*
  Self-checking bench of the complex multiply-accumulate datapath.
  Assumes cma_datapath and cma_trig_src are compiled with cma_defs.svh.
*/
`timescale 1ns/1ps
`default_nettype none

module testbench;
  // ----------------------------------------------------------------------
  // Stimulus and observation
  // ----------------------------------------------------------------------
  logic        clk_i     = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic [18:0] re_exp    = 19'h0_0000;
  logic [18:0] im_exp    = 19'h0_0000;
  logic [18:0] re_pin    = 19'h0_0000;
  logic [18:0] im_pin    = 19'h0_0000;
  logic        en_n      = 1'b0;
  logic [1:0]  sh        = 2'h0;
  logic [15:0] sn        = 16'h0000;
  logic [15:0] cs        = 16'h7FFF;
  logic [31:0] ph        = 32'h0000_0000;
  logic        byp_n     = 1'b1;
  logic        acc       = 1'b0;
  logic [1:0]  sel       = 2'h0;
  logic        fmt_n     = 1'b1;
  logic        pk_n      = 1'b1;
  logic [15:0] sine;
  logic [15:0] cosine;
  logic [19:0] r_out;
  logic [19:0] i_out;
  logic [1:0]  grow;
  int          n_mismatch      = 0;
  int          samples_checked = 0;
  int          cycles          = 0;

  always #20 clk_i = ~clk_i;

  cma_trig_src cma_trig_src_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .sin_req_i(sn),
    .cos_req_i(cs), .sine_o(sine), .cosine_o(cosine));

  cma_datapath cma_datapath_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .real_data_in_i(re_pin), .imag_data_in_i(im_pin), .input_latch_enable_n_i(en_n),
    .input_shift_select_i(sh), .sine_i(sine), .cosine_i(cosine), .phase_word_i(ph),
    .phase_bypass_n_i(byp_n), .accumulate_i(acc), .output_slice_select_i(sel),
    .unsigned_format_n_i(fmt_n), .peak_hold_n_i(pk_n), .real_data_out_o(r_out),
    .imag_data_out_o(i_out), .growth_code_o(grow));

  // ----------------------------------------------------------------------
  // Expected values
  // ----------------------------------------------------------------------
  function automatic logic signed [34:0] lane(logic im);
    logic signed [15:0] rs;
    logic signed [15:0] is;
    logic signed [15:0] so;
    logic signed [15:0] co;
    rs = re_exp[sh +: 16];
    is = im_exp[sh +: 16];
    so = byp_n ? ((sn == 16'h8000) ? 16'h8001 : sn) : ph[31:16];
    co = byp_n ? ((cs == 16'h8000) ? 16'h8001 : cs) : ph[15:0];
    return im ? rs * so + is * co : rs * co - is * so;
  endfunction : lane

  function automatic logic [19:0] word(logic im, int k);
    logic [34:0] a;
    logic [19:0] x;
    logic [19:0] w;
    a = lane(im) * k;
    x = im ? {{4{im_exp[sh + 15]}}, im_exp[sh +: 16]} : {{4{re_exp[sh + 15]}}, re_exp[sh +: 16]};
    case (sel)
      2'h0: w = a[34:15];
      2'h1: w = {a[34:31], 1'b0, a[14:0]};
      2'h2: w = x * k;
      default: w = 20'h0_0000;
    endcase
    w[19] = w[19] ^ ~fmt_n;
    return w;
  endfunction : word

  function automatic logic [1:0] gcode(logic [19:0] w);
    return (w[19] != w[18]) ? 2'h3 : (w[18] != w[17]) ? 2'h2 : (w[17] != w[16]) ? 2'h1 : 2'h0;
  endfunction : gcode

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : stop_test

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      stop_test();
    end
  end

  task automatic cmp(string nm, logic [19:0] e, logic [19:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("unexpected %s expected %h seen %h", nm, e, g);
      n_mismatch++;
    end
  endtask : cmp

  task automatic step(int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : step

  task automatic settle();
    step(6);
  endtask : settle

  task automatic set_in(logic [18:0] r, logic [18:0] i);
    re_exp = r;
    im_exp = i;
    re_pin = r;
    im_pin = i;
  endtask : set_in

  task automatic check_out(int k);
    logic [1:0] gr;
    logic [1:0] gi;
    gr = gcode(word(0, k) ^ {~fmt_n, 19'h0_0000});
    gi = gcode(word(1, k) ^ {~fmt_n, 19'h0_0000});
    cmp("real_data_out_o", word(0, k), r_out);
    cmp("imag_data_out_o", word(1, k), i_out);
    if (pk_n) begin
      cmp("growth_code_o", {18'h0_0000, (gr > gi) ? gr : gi}, {18'h0_0000, grow});
    end
  endtask : check_out

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic sc_shift();
    set_in(19'h5_A5C3, 19'h2_3C71);
    sn = 16'h1234;
    for (int s = 0; s < 4; s++) begin
      for (int m = 0; m < 3; m += 2) begin
        sh  = s[1:0];
        sel = m[1:0];
        settle();
        check_out(1);
      end
    end
    sh = 2'h0;
  endtask : sc_shift

  task automatic sc_mult();
    logic [18:0] tr [4] = '{19'h0_7FFF, 19'h7_8000, 19'h1_C001, 19'h3_FFFF};
    logic [18:0] ti [4] = '{19'h0_0000, 19'h0_1234, 19'h7_F00F, 19'h4_0000};
    logic [15:0] ts [4] = '{16'h0000, 16'h8000, 16'h7FFF, 16'h8001};
    logic [15:0] tc [4] = '{16'h7FFF, 16'h5A5A, 16'h8000, 16'hC3C3};
    for (int n = 0; n < 4; n++) begin
      set_in(tr[n], ti[n]);
      sn = ts[n];
      cs = tc[n];
      for (int m = 0; m < 2; m++) begin
        sel = m[1:0];
        settle();
        check_out(1);
      end
    end
  endtask : sc_mult

  task automatic sc_bypass();
    byp_n = 1'b0;
    ph    = 32'h8000_1234;
    settle();
    check_out(1);
    ph = 32'h7FFF_8000;
    settle();
    check_out(1);
    byp_n = 1'b1;
  endtask : sc_bypass

  task automatic sc_format();
    for (int m = 0; m < 4; m++) begin
      for (int f = 0; f < 2; f++) begin
        sel   = m[1:0];
        fmt_n = f[0];
        settle();
        check_out(1);
      end
    end
  endtask : sc_format

  task automatic sc_latch();
    sel = 2'h0;
    set_in(19'h0_4321, 19'h7_9ABC);
    settle();
    en_n    = 1'b1;
    re_pin  = 19'h1_1111;
    im_pin  = 19'h6_0F0F;
    settle();
    check_out(1);
    en_n = 1'b0;
    step(3);
    check_out(1);
    re_exp = re_pin;
    im_exp = im_pin;
    step(1);
    check_out(1);
  endtask : sc_latch

  task automatic sc_accum();
    set_in(19'h0_7FFF, 19'h0_7FFF);
    sn = 16'h0000;
    cs = 16'h7FFF;
    for (int m = 0; m < 3; m += 2) begin
      for (int j = 4; j < 10; j += 5) begin
        sel = m[1:0];
        settle();
        acc = 1'b1;
        step(j);
        check_out(j);
        acc = 1'b0;
        settle();
        check_out(1);
      end
    end
  endtask : sc_accum

  task automatic sc_peak();
    sel  = 2'h0;
    pk_n = 1'b0;
    settle();
    acc = 1'b1;
    step(9);
    acc = 1'b0;
    settle();
    cmp("growth_code_o", 20'h0_0003, {18'h0_0000, grow});
    pk_n = 1'b1;
    settle();
    check_out(1);
  endtask : sc_peak

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk_i);
    #1;
    sys_rst_i = 1'b0;
    cmp("real_data_out_o", 20'h0_0000, r_out);
    sc_shift();
    sc_mult();
    sc_bypass();
    sc_format();
    sc_latch();
    sc_accum();
    sc_peak();
    stop_test();
  end
endmodule : testbench
`default_nettype wire
